// ==== pkg/break_identity_consts.vh ====
`ifndef BREAK_IDENTITY_CONSTS_VH
`define BREAK_IDENTITY_CONSTS_VH
// System clock rate in Hz
`define BIR_CLK_HZ 100000000
// Minimum break length and forced-mode hold time
`define BIR_BREAK_TIME_MS 250
`define BIR_HOLD_TIME_S 5
`define BIR_BREAK_CYCLES (`BIR_BREAK_TIME_MS * (`BIR_CLK_HZ / 1000))
`define BIR_HOLD_CYCLES (`BIR_HOLD_TIME_S * `BIR_CLK_HZ)
// Baud rates and their codes
`define BIR_BAUD_2400 2400
`define BIR_BAUD_4800 4800
`define BIR_BAUD_9600 9600
`define BIR_BAUD_19200 19200
`define BIR_BAUD_38400 38400
`define BIR_BC_2400 3'h0
`define BIR_BC_4800 3'h1
`define BIR_BC_9600 3'h2
`define BIR_BC_19200 3'h3
`define BIR_BC_38400 3'h4
// Parity codes
`define BIR_PAR_NONE 2'h0
`define BIR_PAR_ODD 2'h1
`define BIR_PAR_EVEN 2'h2
// Frame bytes
`define BIR_STX 8'h02
`define BIR_ETX 8'h03
`define BIR_TYPE_IDENT 8'h6e
`define BIR_TYPE_SCREEN 8'h82
`define BIR_SCREEN_COUNT 8'ha1
`define BIR_SCREEN_BYTES 8'ha0
// Register byte offsets
`define BIR_REG_CTRL 12'h000
`define BIR_REG_STATUS 12'h004
`define BIR_REG_CURSOR 12'h008
`define BIR_REG_SCREEN 12'h100
`define BIR_SCREEN_WORDS 6'h28
// Control register fields
`define BIR_CTRL_BIN 2:0
`define BIR_CTRL_BOUT 5:3
`define BIR_CTRL_PAR 7:6
`define BIR_CTRL_ACK 8
`define BIR_CTRL_PROTO 11:9
`define BIR_CTRL_RESET 12'h612
// AXI responses
`define BIR_RESP_OKAY 2'h0
`define BIR_RESP_SLVERR 2'h2
// Fifo depth
`define BIR_FIFO_DEPTH 32
`endif

// ==== core/break_identity_responder.v ====
// Contract
// - Break of 250 ms requests identity report
// - Break forces port to 9600 8N1
// - Identity report then sent on same port
// - Frame: start, status, type, count, payload, checksum, end
// - Four strings back to back, no separators
// - Product string: keyword, comma, fixed identifier, semicolon
// - Port string fields comma separated, semicolon end
// - Baud fields from five decimal rates
// - Data bits 8, stop 1, parity O/E/N
// - Port string shows configured, not forced, settings
// - Flag T keeps 9600 8N1 five seconds
// - Flag F restores settings after report
// - Version string: number, slashed date, two empties
// - Protocol string: keyword, codes list, semicolon
// - Screen request answered by screen report
// - Screen report: fixed count, screen, cursor byte
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "break_identity_consts.vh"

// Byte fifo between the framer and the serial transmitter
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = `BIR_FIFO_DEPTH,
   parameter AW = 5
) (
   input wire core_clk, // System clock
   input wire nrst, // Async reset, active low
   input wire [WIDTH-1:0] inData, // Write data
   input wire inValid, // Write request
   output wire inReady, // Space available
   output wire [WIDTH-1:0] outData, // Head entry
   output wire outValid, // Entry available
   input wire outReady // Reader takes head
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
   reg [AW-1:0] wrPtr_r; // Write pointer
   reg [AW-1:0] rdPtr_r; // Read pointer
   reg [AW:0] count_r; // Fill level
   wire doWr = inValid && inReady;
   wire doRd = outValid && outReady;
   assign inReady = (count_r != DEPTH[AW:0]);
   assign outValid = (count_r != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_r];
   // Storage has no reset; only the pointers matter
   always @(posedge core_clk) begin
      if (doWr) begin
         mem[wrPtr_r] <= inData;
      end
   end
   // Pointers wrap at DEPTH, which must be a power of two
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (doWr) wrPtr_r <= wrPtr_r + 1'b1;
         if (doRd) rdPtr_r <= rdPtr_r + 1'b1;
         if (doWr && !doRd) count_r <= count_r + 1'b1;
         else if (doRd && !doWr) count_r <= count_r - 1'b1;
      end
   end
endmodule

module break_identity_responder #(
   parameter [31:0] BREAK_CYCLES = `BIR_BREAK_CYCLES,
   parameter [31:0] HOLD_CYCLES = `BIR_HOLD_CYCLES,
   parameter [63:0] PRODUCT_ID = "RCVRUNIT", // Arbitrary value
   parameter [127:0] VERSION_TEXT = "1.00,01/01/00",
   parameter [7:0] VERSION_LEN = 8'h0d
) (
   input wire core_clk, // System clock, 100 MHz
   input wire nrst, // Async reset, active low
   input wire [11:0] s_axi_awaddr, // Write address
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Byte strobes
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   output reg [1:0] s_axi_bresp, // Write response
   output reg s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [11:0] s_axi_araddr, // Read address
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   output reg [31:0] s_axi_rdata, // Read data
   output reg [1:0] s_axi_rresp, // Read response
   output reg s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   input wire rxd, // Serial receive line
   output reg txd, // Serial transmit line
   input wire scrReq, // Screen dump request pulse
   input wire [7:0] statusByte, // Receiver status byte
   input wire [7:0] checksumByte, // Checksum from outside unit
   output reg [7:0] txByte, // Byte that entered the fifo
   output reg txByteValid, // Pulse per byte entered
   output reg forcedMode, // Port held at 9600 8N1
   output wire frameBusy // Report or forced-mode hold in progress
);
   localparam ST_IDLE = 7'h01, ST_HEAD = 7'h02, ST_BODY = 7'h04, ST_SCRN = 7'h08;
   localparam ST_TAIL = 7'h10, ST_DRAIN = 7'h20, ST_HOLD = 7'h40;
   localparam [4:0] LAST_TOK = 5'h10;
   reg [11:0] ctrl_r; // Configured port and protocol settings
   reg [11:0] snap_r; // Settings frozen at report start
   reg [7:0] cursor_r; // Cursor position
   reg [31:0] scr [0:39]; // Screen text, four chars a word
   reg [6:0] st_r; // Framer state
   reg kindScr_r; // Current report is a screen dump
   reg [7:0] idx_r; // Byte index inside a section
   reg [4:0] tok_r; // Token index inside the payload
   reg [31:0] lowCnt_r; // Cycles the line has been low
   reg breakPend_r; // Break seen, not yet served
   reg scrPend_r; // Screen request not yet served
   reg [31:0] holdCnt_r; // Forced-mode hold counter
   reg awHeld_r, wHeld_r; // Write halves captured
   reg [11:0] awAddr_r; // Captured write address
   reg [31:0] wData_r; // Captured write data
   reg [3:0] wStrb_r; // Captured strobes
   reg [15:0] divCnt_r; // Baud divider
   reg [15:0] div_r; // Bit period of current byte
   reg [10:0] sh_r; // Transmit shift register
   reg [3:0] bitsLeft_r; // Bits still to send
   reg [127:0] tokText; // Current token text, right aligned
   reg [7:0] tokLen; // Current token length
   reg [7:0] frameByte; // Byte offered to the fifo
   reg frameValid; // Byte offer
   wire fifoInReady, fifoOutValid; // Fifo handshakes
   wire [7:0] fifoOutData; // Fifo head
   wire txIdle = (bitsLeft_r == 4'h0);

   // Decimal text of a baud code
   function [39:0] baudTxt(input [2:0] c);
      begin
         case (c)
            `BIR_BC_2400: baudTxt = "2400";
            `BIR_BC_4800: baudTxt = "4800";
            `BIR_BC_19200: baudTxt = "19200";
            `BIR_BC_38400: baudTxt = "38400";
            default: baudTxt = "9600";
         endcase
      end
   endfunction
   // Digit count of a baud code
   function [7:0] baudLen(input [2:0] c);
      begin
         baudLen = (c == `BIR_BC_19200 || c == `BIR_BC_38400) ? 8'h05 : 8'h04;
      end
   endfunction
   // Bit period in cycles of a baud code; periods round down
   function [15:0] baudDiv(input [2:0] c);
      reg [31:0] d;
      begin
         case (c)
            `BIR_BC_2400: d = `BIR_CLK_HZ / `BIR_BAUD_2400;
            `BIR_BC_4800: d = `BIR_CLK_HZ / `BIR_BAUD_4800;
            `BIR_BC_19200: d = `BIR_CLK_HZ / `BIR_BAUD_19200;
            `BIR_BC_38400: d = `BIR_CLK_HZ / `BIR_BAUD_38400;
            default: d = `BIR_CLK_HZ / `BIR_BAUD_9600;
         endcase
         baudDiv = d[15:0];
      end
   endfunction

   // Payload byte count, computed from the frozen settings
   wire [7:0] protoCnt = {7'h00, snap_r[9]} + {7'h00, snap_r[10]} + {7'h00, snap_r[11]};
   wire [7:0] identLen = 8'h30 + VERSION_LEN + baudLen(snap_r[`BIR_CTRL_BIN])
      + baudLen(snap_r[`BIR_CTRL_BOUT]) + {protoCnt[5:0], 2'b00} + protoCnt;

   // Token table; the strings follow each other with no separators
   always @* begin
      tokText = 128'h0;
      tokLen = 8'h00;
      case (tok_r)
         5'h00: begin tokText = "PRODUCT,"; tokLen = 8'h08; end
         5'h01: begin tokText = {64'h0, PRODUCT_ID}; tokLen = 8'h08; end
         5'h02: begin tokText = ";PORT,"; tokLen = 8'h06; end
         5'h03: begin // Configured input rate, not the forced one
            tokText = {88'h0, baudTxt(snap_r[`BIR_CTRL_BIN])};
            tokLen = baudLen(snap_r[`BIR_CTRL_BIN]);
         end
         5'h04: begin tokText = ","; tokLen = 8'h01; end
         5'h05: begin // Configured output rate
            tokText = {88'h0, baudTxt(snap_r[`BIR_CTRL_BOUT])};
            tokLen = baudLen(snap_r[`BIR_CTRL_BOUT]);
         end
         5'h06: begin tokText = ",8,1,"; tokLen = 8'h05; end
         5'h07: begin // Parity letter
            tokLen = 8'h01;
            case (snap_r[`BIR_CTRL_PAR])
               `BIR_PAR_ODD: tokText = "O";
               `BIR_PAR_EVEN: tokText = "E";
               default: tokText = "N";
            endcase
         end
         5'h08: begin tokText = ","; tokLen = 8'h01; end
         5'h09: begin // Acknowledge flag
            tokText = snap_r[`BIR_CTRL_ACK] ? "T" : "F";
            tokLen = 8'h01;
         end
         5'h0a: begin tokText = ";VERSION,"; tokLen = 8'h09; end
         5'h0b: begin tokText = VERSION_TEXT; tokLen = VERSION_LEN; end
         5'h0c: begin tokText = ",,;COMM"; tokLen = 8'h07; end
         5'h0d: begin // Collector format code, ASCII
            tokText = {88'h0, 8'h2c, 32'h44434f4c};
            tokLen = snap_r[9] ? 8'h05 : 8'h00;
         end
         5'h0e: begin tokText = ",NMEA"; tokLen = snap_r[10] ? 8'h05 : 8'h00; end
         5'h0f: begin tokText = ",RTCM"; tokLen = snap_r[11] ? 8'h05 : 8'h00; end
         5'h10: begin tokText = ";"; tokLen = 8'h01; end
         default: begin tokText = 128'h0; tokLen = 8'h00; end
      endcase
   end

   // Byte offered to the fifo in each framing state
   wire [7:0] tokSh = tokLen - 8'h01 - idx_r;
   wire [127:0] tokShifted = tokText >> {tokSh, 3'b000};
   wire [31:0] scrWord = scr[idx_r[7:2]];
   wire [31:0] scrShifted = scrWord >> {idx_r[1:0], 3'b000};
   always @* begin
      frameByte = 8'h00;
      frameValid = 1'b0;
      case (st_r)
         ST_HEAD: begin // Start, status, type, count
            frameValid = 1'b1;
            case (idx_r[1:0])
               2'h0: frameByte = `BIR_STX;
               2'h1: frameByte = statusByte;
               2'h2: frameByte = kindScr_r ? `BIR_TYPE_SCREEN : `BIR_TYPE_IDENT;
               default: frameByte = kindScr_r ? `BIR_SCREEN_COUNT : identLen;
            endcase
         end
         ST_BODY: begin // Empty tokens are skipped without a byte
            frameValid = (tokLen != 8'h00);
            frameByte = tokShifted[7:0];
         end
         ST_SCRN: begin // Screen chars then cursor
            frameValid = 1'b1;
            frameByte = (idx_r == `BIR_SCREEN_BYTES) ? cursor_r : scrShifted[7:0];
         end
         ST_TAIL: begin // Checksum then end byte
            frameValid = 1'b1;
            frameByte = idx_r[0] ? `BIR_ETX : checksumByte;
         end
         default: begin
            frameByte = 8'h00;
            frameValid = 1'b0;
         end
      endcase
   end
   wire push = frameValid && fifoInReady;
   // Registered copy of each accepted byte; observers see it one cycle late
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         txByte <= 8'h00;
         txByteValid <= 1'b0;
      end else begin
         txByte <= frameByte;
         txByteValid <= push;
      end
   end
   assign frameBusy = (st_r != ST_IDLE);

   // Break detector: line low without a break in the count
   wire breakHit = (lowCnt_r == BREAK_CYCLES - 32'h1) && !rxd;
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lowCnt_r <= 32'h0;
      end else if (rxd) begin
         lowCnt_r <= 32'h0;
      end else if (lowCnt_r != BREAK_CYCLES) begin
         lowCnt_r <= lowCnt_r + 32'h1;
      end
   end

   // Framer sequencer and forced-mode control
   wire startId = (st_r == ST_IDLE) && breakPend_r;
   wire startScr = (st_r == ST_IDLE) && !breakPend_r && scrPend_r;
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_IDLE;
         kindScr_r <= 1'b0;
         idx_r <= 8'h00;
         tok_r <= 5'h00;
         snap_r <= `BIR_CTRL_RESET;
         breakPend_r <= 1'b0;
         scrPend_r <= 1'b0;
         forcedMode <= 1'b0;
         holdCnt_r <= 32'h0;
      end else begin
         // A new event in the serving cycle wins over the clear
         if (breakHit) breakPend_r <= 1'b1;
         else if (startId) breakPend_r <= 1'b0;
         if (scrReq) scrPend_r <= 1'b1;
         else if (startScr) scrPend_r <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               idx_r <= 8'h00;
               tok_r <= 5'h00;
               snap_r <= ctrl_r;
               if (startId) begin
                  kindScr_r <= 1'b0;
                  forcedMode <= 1'b1;
                  st_r <= ST_HEAD;
               end else if (startScr) begin
                  kindScr_r <= 1'b1;
                  st_r <= ST_HEAD;
               end
            end
            ST_HEAD: if (push) begin
               idx_r <= idx_r + 8'h01;
               if (idx_r == 8'h03) begin
                  idx_r <= 8'h00;
                  st_r <= kindScr_r ? ST_SCRN : ST_BODY;
               end
            end
            ST_BODY: if (tokLen == 8'h00 || (push && idx_r == tokLen - 8'h01)) begin
               idx_r <= 8'h00;
               tok_r <= tok_r + 5'h01;
               if (tok_r == LAST_TOK) st_r <= ST_TAIL;
            end else if (push) begin
               idx_r <= idx_r + 8'h01;
            end
            ST_SCRN: if (push) begin
               idx_r <= idx_r + 8'h01;
               if (idx_r == `BIR_SCREEN_BYTES) begin
                  idx_r <= 8'h00;
                  st_r <= ST_TAIL;
               end
            end
            ST_TAIL: if (push) begin
               idx_r <= idx_r + 8'h01;
               if (idx_r[0]) st_r <= ST_DRAIN;
            end
            ST_DRAIN: if (!fifoOutValid && txIdle) begin
               // Last stop bit is out on the line
               holdCnt_r <= 32'h0;
               if (!kindScr_r && snap_r[`BIR_CTRL_ACK]) begin
                  st_r <= ST_HOLD;
               end else begin
                  if (!kindScr_r) forcedMode <= 1'b0;
                  st_r <= ST_IDLE;
               end
            end
            ST_HOLD: begin // Hold counted from the end of the report
               holdCnt_r <= holdCnt_r + 32'h1;
               if (holdCnt_r == HOLD_CYCLES - 32'h1) begin
                  forcedMode <= 1'b0;
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   byte_fifo #(.WIDTH(8), .DEPTH(`BIR_FIFO_DEPTH), .AW(5)) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .inData(frameByte),
      .inValid(frameValid),
      .inReady(fifoInReady),
      .outData(fifoOutData),
      .outValid(fifoOutValid),
      .outReady(txIdle)
   );

   // Serial transmitter; forced mode overrides the configured format
   wire [2:0] txBaud = forcedMode ? `BIR_BC_9600 : ctrl_r[`BIR_CTRL_BOUT];
   wire [1:0] txPar = forcedMode ? `BIR_PAR_NONE : ctrl_r[`BIR_CTRL_PAR];
   wire parBit = (txPar == `BIR_PAR_ODD) ? ~^fifoOutData : ^fifoOutData;
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         txd <= 1'b1;
         sh_r <= 11'h7ff;
         bitsLeft_r <= 4'h0;
         divCnt_r <= 16'h0;
         div_r <= 16'h0;
      end else if (txIdle) begin
         txd <= 1'b1;
         if (fifoOutValid) begin
            div_r <= baudDiv(txBaud);
            divCnt_r <= 16'h0;
            txd <= 1'b0; // Start bit
            if (txPar == `BIR_PAR_NONE) begin
               sh_r <= {2'b11, fifoOutData, 1'b0};
               bitsLeft_r <= 4'ha;
            end else begin
               sh_r <= {1'b1, parBit, fifoOutData, 1'b0};
               bitsLeft_r <= 4'hb;
            end
         end
      end else if (divCnt_r == div_r - 16'h1) begin
         divCnt_r <= 16'h0;
         sh_r <= {1'b1, sh_r[10:1]};
         txd <= sh_r[1];
         bitsLeft_r <= bitsLeft_r - 4'h1;
      end else begin
         divCnt_r <= divCnt_r + 16'h1;
      end
   end

   // AXI4-Lite write side: halves taken in either order
   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
   wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire wrScr = (awAddr_r[11:8] == 4'h1) && (awAddr_r[7:2] < `BIR_SCREEN_WORDS);
   wire wrKnown = wrScr || awAddr_r == `BIR_REG_CTRL || awAddr_r == `BIR_REG_STATUS
      || awAddr_r == `BIR_REG_CURSOR;
   integer lane;
   always @(posedge core_clk) begin
      if (doWrite && wrScr) begin
         for (lane = 0; lane < 4; lane = lane + 1) begin
            if (wStrb_r[lane]) scr[awAddr_r[7:2]][lane*8 +: 8] <= wData_r[lane*8 +: 8];
         end
      end
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 12'h0;
         wData_r <= 32'h0;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BIR_RESP_OKAY;
         ctrl_r <= `BIR_CTRL_RESET;
         cursor_r <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrKnown ? `BIR_RESP_OKAY : `BIR_RESP_SLVERR;
            if (awAddr_r == `BIR_REG_CTRL) begin
               if (wStrb_r[0]) ctrl_r[7:0] <= wData_r[7:0];
               if (wStrb_r[1]) ctrl_r[11:8] <= wData_r[11:8];
            end
            if (awAddr_r == `BIR_REG_CURSOR && wStrb_r[0]) cursor_r <= wData_r[7:0];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read side: answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   wire [11:0] rdAddr = {s_axi_araddr[11:2], 2'b00};
   wire rdScr = (rdAddr[11:8] == 4'h1) && (rdAddr[7:2] < `BIR_SCREEN_WORDS);
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `BIR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `BIR_RESP_OKAY;
         if (rdScr) s_axi_rdata <= scr[rdAddr[7:2]];
         else if (rdAddr == `BIR_REG_CTRL) s_axi_rdata <= {20'h0, ctrl_r};
         else if (rdAddr == `BIR_REG_STATUS) s_axi_rdata <= {28'h0, breakPend_r,
            (st_r == ST_HOLD), forcedMode, frameBusy};
         else if (rdAddr == `BIR_REG_CURSOR) s_axi_rdata <= {24'h0, cursor_r};
         else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `BIR_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ==== verif/break_identity_assertions.sv ====
`timescale 1ns/1ns
module break_identity_assertions #(
   parameter [31:0] BREAK_CYCLES = 200
) (
   input wire core_clk, // Clock
   input wire nrst, // Reset
   input wire s_axi_awready, // Aw ready
   input wire s_axi_wready, // W ready
   input wire s_axi_bvalid, // B valid
   input wire s_axi_bready, // B ready
   input wire s_axi_arvalid, // Ar valid
   input wire s_axi_arready, // Ar ready
   input wire s_axi_rvalid, // R valid
   input wire s_axi_rready, // R ready
   input wire rxd, // Rx line
   input wire txd, // Tx line
   input wire [7:0] statusByte, // Status
   input wire [7:0] txByte, // Fifo byte
   input wire txByteValid, // Fifo push
   input wire forcedMode, // Forced 9600
   input wire frameBusy // Busy
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [31:0] lowCnt_r; // Low samples in a row
   // Saturates so a stuck line never wraps into a false break
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) lowCnt_r <= 32'h0;
      else if (rxd) lowCnt_r <= 32'h0;
      else if (lowCnt_r != 32'hffffffff) lowCnt_r <= lowCnt_r + 32'h1;
   end
   // Start byte, then status byte pushed next cycle
   sequence s_head;
      txByteValid && txByte == 8'h02 ##1 txByteValid && txByte == statusByte;
   endsequence
   a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_break_forces: assert property (
      !rxd && lowCnt_r == BREAK_CYCLES - 1 && !frameBusy |-> ##[1:4] forcedMode)
      else $error("break not served");
   a_report_head: assert property ($rose(forcedMode) |-> ##[0:2] s_head)
      else $error("bad report head");
   a_tx_idle_high: assert property (!frameBusy |-> txd)
      else $error("txd low while idle");
   a_forced_busy: assert property (forcedMode |-> frameBusy)
      else $error("forced while idle");
endmodule
bind break_identity_responder break_identity_assertions #(.BREAK_CYCLES(BREAK_CYCLES))
   u_break_identity_assertions (.*);

// ==== verif/remote_host.sv ====
`timescale 1ns/1ns
module remote_host #(
   parameter int BIT_CYC = 100000000 / 9600
) (
   input wire core_clk, // Clock
   output logic rxd, // Line into block
   input wire txd // Line from block
);
   initial rxd = 1'h1;
   // Spacing level for n cycles, then back to marking
   task automatic send_break(input int n);
      @(posedge core_clk);
      rxd <= 1'h0;
      repeat (n) @(posedge core_clk);
      rxd <= 1'h1;
   endtask
   // Samples at mid bit, LSB first; a wrong rate misses the centres
   task automatic get_bits(input int k, output logic [7:0] b, output int ok);
      int w;
      w = 0;
      b = 8'h0;
      while (txd !== 1'h0 && w < 20000) begin
         @(posedge core_clk);
         w++;
      end
      repeat (BIT_CYC / 2) @(posedge core_clk);
      ok = (w < 20000) && (txd === 1'h0);
      for (int i = 0; i < k; i++) begin
         repeat (BIT_CYC) @(posedge core_clk);
         b[i] = txd;
      end
   endtask
endmodule

// ==== verif/break_identity_responder_tb_top.sv ====
`timescale 1ns/1ns
module break_identity_responder_tb_top;
   localparam int BRK = 200; // Short break length
   logic core_clk = 1'h0, nrst = 1'h0, scrReq = 1'h0; // Clock, reset, screen request
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0; // Addresses
   logic [31:0] s_axi_wdata = 32'h0; // Write data
   logic [3:0] s_axi_wstrb = 4'h0; // Lanes
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0; // Write strobes
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0; // Read strobes
   logic [7:0] statusByte = 8'h5a, checksumByte = 8'hc3; // Fixed frame fields
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // Readies
   wire txd, rxd, txByteValid, forcedMode, frameBusy; // Serial side
   wire [1:0] s_axi_bresp, s_axi_rresp; // Responses
   wire [31:0] s_axi_rdata; // Read data
   wire [7:0] txByte; // Fifo byte
   logic [7:0] q[$]; // Pushed bytes
   int error_cnt = 0, tests_run = 0; // Tally
   break_identity_responder #(.BREAK_CYCLES(BRK), .HOLD_CYCLES(300))
      u_break_identity_responder (.*);
   remote_host u_remote_host (.*);
   always #5 core_clk = ~core_clk;
   // Record every byte the framer hands to the fifo
   always @(posedge core_clk) begin
      if (nrst && txByteValid === 1'h1) q.push_back(txByte);
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   // Header bytes, then the text expected at the front of the payload
   task automatic chk_q(input logic [7:0] ty, input logic [7:0] n, input string s);
      logic [7:0] e[$];
      e = {8'h02, statusByte, ty, n};
      for (int i = 0; i < s.len(); i++) e.push_back(s[i]);
      for (int i = 0; i < e.size(); i++)
         chk("txByte", {24'h0, e[i]}, {24'h0, (i < q.size() ? q[i] : 8'hxx)});
   endtask
   task automatic do_reset;
      nrst <= 1'h0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'h1;
      q.delete();
   endtask
   task automatic t_regs;
      rd(12'h000, 32'h0000_0612, 2'h0);
      rd(12'h004, 32'h0, 2'h0);
      rd(12'h0f0, 32'h0, 2'h2);
      wr(12'h0f0, 32'h1, 2'h2);
      wr(12'h000, 32'h0000_0ba4, 2'h0);
      rd(12'h000, 32'h0000_0ba4, 2'h0);
   endtask
   task automatic t_short_break;
      u_remote_host.send_break(BRK - 60);
      repeat (20) @(posedge core_clk);
      chk("frameBusy", 32'h0, {31'h0, frameBusy});
   endtask
   // Port set to 38400 with even parity; report must still go at 9600
   task automatic t_identity;
      logic [7:0] b;
      int ok;
      u_remote_host.send_break(BRK + 20);
      u_remote_host.get_bits(2, b, ok);
      chk("startBit", 32'h1, ok);
      chk("txBits", 32'h2, {30'h0, b[1:0]});
      chk("forcedMode", 32'h1, {31'h0, forcedMode});
      chk_q(8'h6e, 8'(48 + 13 + 10 + 10), "PRODUCT,RCVRUNIT;PORT,38400,");
      do_reset;
   endtask
   task automatic t_screen;
      wr(12'h100, 32'h4443_4241, 2'h0);
      @(posedge core_clk);
      scrReq <= 1'h1;
      @(posedge core_clk);
      scrReq <= 1'h0;
      repeat (60) @(posedge core_clk);
      chk_q(8'h82, 8'ha1, "ABCD");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      do_reset;
      t_regs;
      t_short_break;
      t_identity;
      t_screen;
      tally_and_finish;
   end
   // About 30000 cycles are needed; double that means a hang
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      tally_and_finish;
   end
endmodule
